// File: src/tccr_map.svh
// address spaces, register addresses and reset values of the compare/capture register set
`ifndef TCCR_MAP_SVH
`define TCCR_MAP_SVH

// ******************************************
// address spaces
// ******************************************
`define TCCR_IO_LAST        8'h3F
`define TCCR_DATA_OFFSET    8'h20
`define TCCR_EXT_FIRST      8'h60

// ******************************************
// register offsets (data space, plus the I/O-space timer 1 capture pair)
// ******************************************
`define TCCR_T1_CAPTURE_IO_LO 8'h26
`define TCCR_T1_CAPTURE_IO_HI 8'h27
`define TCCR_T1_CAPTURE_LO    8'h46
`define TCCR_T1_CAPTURE_HI    8'h47
`define TCCR_T1_MATCH_C_LO    8'h78
`define TCCR_T1_MATCH_C_HI    8'h79
`define TCCR_T3_MATCH_C_LO    8'h82
`define TCCR_T3_MATCH_C_HI    8'h83
`define TCCR_T3_MATCH_B_LO    8'h84
`define TCCR_T3_MATCH_B_HI    8'h85
`define TCCR_T3_MATCH_A_LO    8'h86
`define TCCR_T3_MATCH_A_HI    8'h87

// ******************************************
// reset values
// ******************************************
`define TCCR_BYTE_RESET     8'h00
`define TCCR_WORD_RESET     16'h0000

`endif

// File: src/tccr_pkg.sv
// types of the compare/capture register set
`default_nettype none
package tccr_pkg;
  typedef logic [7:0]  tccr_byte_t;
  typedef logic [15:0] tccr_word_t;

  // top value selection handed to the counter
  typedef enum logic [1:0] {
    TCCR_TOP_FIXED,
    TCCR_TOP_CAPTURE,
    TCCR_TOP_MATCH
  } tccr_top_e;

  typedef struct packed {
    tccr_byte_t temp;
    tccr_word_t t1_capture;
    tccr_word_t t1_match_c;
    tccr_word_t t3_match_a;
    tccr_word_t t3_match_b;
    tccr_word_t t3_match_c;
    tccr_byte_t rdata;
    logic       t1_pin_s1;
    logic       t1_pin_s2;
    logic       t1_pin_old;
    logic       t1_cmp_s1;
    logic       t1_cmp_s2;
    logic       t1_cmp_old;
    logic       t1_capture_evt;
    logic       t1_block;
    logic       t3_block;
    logic       t1_top_capture;
  } tccr_state_s;
endpackage
`default_nettype wire

// File: src/tccr_regs.sv
// compare and capture registers of timers 1 and 3 behind the byte-wide I/O port
//
// Function
// R1: an edge on the capture trigger pin copies the counter value into the capture register.
// R2: timer 1 may take the comparator output instead of its pin as capture trigger.
// R3: the capture register can be offered to the counter as its top value.
// R4: every 16-bit register moves both bytes together through an 8-bit temporary latch.
// R5: one temporary latch is shared by all 16-bit registers.
// R6: the cpu uses I/O addresses 0x00 to 0x3F with its I/O instructions.
// R7: data-space addresses of low I/O registers are the I/O offset plus 0x20.
// R8: registers from 0x60 upward are reached by data-space loads and stores only.
// R9: timer 1 capture low and high sit at data addresses 0x46 and 0x47.
// R10: timer 1 compare C low/high sit at 0x78/0x79, read/write, reset to zero.
// R11: timer 3 compare A low/high sit at 0x86/0x87, read/write, reset to zero.
// R12: timer 3 compare B low/high sit at 0x84/0x85, read/write, reset to zero.
// R13: timer 3 compare C low/high sit at 0x82/0x83, read/write, reset to zero.
// R14: timer 1 capture low/high sit at I/O 0x26/0x27, read/write, reset to zero.
// R15: a cpu write to a counter blocks that timer's compare matches on the next timer clock.
// R16: a high-byte write lands in the latch; the low-byte write commits both bytes at once.
// R17: a low-byte read loads the high byte into the latch, returned by the next high read.
`include "tccr_map.svh"
`default_nettype none
module tccr_regs #(
  parameter int ADDR_W = 8
) (
  input  wire logic              CLK,
  input  wire logic              NRST,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic              IO_SPACE,
  input  wire logic              WR_EN,
  input  wire logic              RD_EN,
  input  wire logic [7:0]        WDATA,
  output logic      [7:0]        RDATA,
  input  wire logic [15:0]       T1_TIMER_COUNT_VALUE,
  input  wire logic [15:0]       T3_TIMER_COUNT_VALUE,
  input  wire logic              T1_CAPTURE_TRIGGER_PIN,
  input  wire logic              T1_COMPARATOR_OUT,
  input  wire logic              T1_SEL_COMPARATOR,
  input  wire logic              T1_CAPTURE_RISING,
  input  wire logic              T1_TOP_IS_CAPTURE,
  input  wire logic              T1_COUNT_WRITE,
  input  wire logic              T3_COUNT_WRITE,
  input  wire logic              T1_TIMER_TICK,
  input  wire logic              T3_TIMER_TICK,
  output logic      [15:0]       T1_CAPTURE,
  output logic      [15:0]       T1_MATCH_C,
  output logic      [15:0]       T3_MATCH_A,
  output logic      [15:0]       T3_MATCH_B,
  output logic      [15:0]       T3_MATCH_C,
  output logic      [15:0]       T1_TOP_VALUE,
  output logic                   T1_CAPTURE_EVENT,
  output logic                   T1_MATCH_BLOCK,
  output logic                   T3_MATCH_BLOCK,
  output logic                   T1_TOP_FROM_CAPTURE
);

  initial begin
    if (ADDR_W != 8) begin
      $error("tccr_regs: ADDR_W must be 8");
    end
  end

  tccr_pkg::tccr_state_s s_q;
  tccr_pkg::tccr_state_s s_d;

  // ******************************************
  // address decode
  // ******************************************
  // io instructions reach only 0x00..0x3F; fold them into data space so one map serves both
  function automatic logic [7:0] to_data(input logic [7:0] a, input logic io);
    logic [7:0] r;
    r = a;
    if (io) begin
      r = (a <= `TCCR_IO_LAST) ? 8'(a + `TCCR_DATA_OFFSET) : 8'hFF; // R6 R7
    end
    return r;
  endfunction

  // index of the addressed 16-bit register, zero for an unmapped address
  function automatic logic [2:0] reg_sel(input logic [7:0] a);
    logic [2:0] r;
    r = 3'h0;
    unique case (a)
      `TCCR_T1_CAPTURE_LO, `TCCR_T1_CAPTURE_HI: r = 3'h1; // R9 R14
      `TCCR_T1_MATCH_C_LO, `TCCR_T1_MATCH_C_HI: r = 3'h2; // R10 R8
      `TCCR_T3_MATCH_A_LO, `TCCR_T3_MATCH_A_HI: r = 3'h3; // R11
      `TCCR_T3_MATCH_B_LO, `TCCR_T3_MATCH_B_HI: r = 3'h4; // R12
      `TCCR_T3_MATCH_C_LO, `TCCR_T3_MATCH_C_HI: r = 3'h5; // R13
      default: r = 3'h0;
    endcase
    return r;
  endfunction

  logic [7:0]  daddr;
  logic [2:0]  sel;
  logic        is_low;
  logic [15:0] cur;
  logic [15:0] upd;
  logic        pin_edge;
  logic        cmp_edge;

  always_comb begin
    daddr = to_data(ADDR, IO_SPACE);
    sel = reg_sel(daddr);
    is_low = ~daddr[0];
    s_d = s_q;
    s_d.t1_capture_evt = 1'b0;
    unique case (sel)
      3'h1: cur = s_q.t1_capture;
      3'h2: cur = s_q.t1_match_c;
      3'h3: cur = s_q.t3_match_a;
      3'h4: cur = s_q.t3_match_b;
      3'h5: cur = s_q.t3_match_c;
      default: cur = `TCCR_WORD_RESET;
    endcase
    upd = {s_q.temp, WDATA}; // R4 R16

    // ******************************************
    // cpu writes
    // ******************************************
    if (WR_EN && sel != 3'h0) begin
      if (!is_low) begin
        s_d.temp = WDATA; // R5 R16
      end else begin
        unique case (sel)
          3'h1: s_d.t1_capture = upd; // R14
          3'h2: s_d.t1_match_c = upd; // R10
          3'h3: s_d.t3_match_a = upd; // R11
          3'h4: s_d.t3_match_b = upd; // R12
          3'h5: s_d.t3_match_c = upd; // R13
          default: s_d.t3_match_c = s_q.t3_match_c;
        endcase
      end
    end

    // ******************************************
    // cpu reads
    // ******************************************
    // unmapped addresses read zero; the byte shows the cycle after the strobe
    s_d.rdata = `TCCR_BYTE_RESET;
    if (RD_EN && sel != 3'h0) begin
      if (is_low) begin
        s_d.rdata = cur[7:0];
        s_d.temp = cur[15:8]; // R17 R5
      end else begin
        s_d.rdata = s_q.temp; // R17
      end
    end

    // ******************************************
    // capture trigger
    // ******************************************
    // pin and comparator are asynchronous: two flops each before the edge detector
    s_d.t1_pin_s1 = T1_CAPTURE_TRIGGER_PIN;
    s_d.t1_pin_s2 = s_q.t1_pin_s1;
    s_d.t1_pin_old = s_q.t1_pin_s2;
    s_d.t1_cmp_s1 = T1_COMPARATOR_OUT;
    s_d.t1_cmp_s2 = s_q.t1_cmp_s1;
    s_d.t1_cmp_old = s_q.t1_cmp_s2;
    pin_edge = T1_CAPTURE_RISING ? (s_q.t1_pin_s2 & ~s_q.t1_pin_old)
                                 : (~s_q.t1_pin_s2 & s_q.t1_pin_old);
    cmp_edge = T1_CAPTURE_RISING ? (s_q.t1_cmp_s2 & ~s_q.t1_cmp_old)
                                 : (~s_q.t1_cmp_s2 & s_q.t1_cmp_old);
    // a hardware capture overrides a cpu write of the same cycle
    if (T1_SEL_COMPARATOR ? cmp_edge : pin_edge) begin // R2
      s_d.t1_capture = T1_TIMER_COUNT_VALUE; // R1
      s_d.t1_capture_evt = 1'b1;
    end

    // ******************************************
    // compare blocking after counter writes
    // ******************************************
    // held until the next timer tick, then dropped once that tick has passed
    if (T1_COUNT_WRITE) begin
      s_d.t1_block = 1'b1; // R15
    end else if (T1_TIMER_TICK) begin
      s_d.t1_block = 1'b0; // R15
    end
    if (T3_COUNT_WRITE) begin
      s_d.t3_block = 1'b1; // R15
    end else if (T3_TIMER_TICK) begin
      s_d.t3_block = 1'b0; // R15
    end

    s_d.t1_top_capture = T1_TOP_IS_CAPTURE; // R3
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ******************************************
  // outputs
  // ******************************************
  assign RDATA               = s_q.rdata;
  assign T1_CAPTURE          = s_q.t1_capture;
  assign T1_MATCH_C          = s_q.t1_match_c;
  assign T3_MATCH_A          = s_q.t3_match_a;
  assign T3_MATCH_B          = s_q.t3_match_b;
  assign T3_MATCH_C          = s_q.t3_match_c;
  assign T1_TOP_VALUE        = s_q.t1_capture; // R3
  assign T1_CAPTURE_EVENT    = s_q.t1_capture_evt;
  assign T1_MATCH_BLOCK      = s_q.t1_block;
  assign T3_MATCH_BLOCK      = s_q.t3_block;
  assign T1_TOP_FROM_CAPTURE = s_q.t1_top_capture;

  // T3 count input is reserved for a later capture channel on timer 3
  logic unused_t3;
  assign unused_t3 = ^T3_TIMER_COUNT_VALUE;

endmodule
`default_nettype wire

// File: verification/tccr_cpu.sv
// cpu side model that drives the byte-wide register port
`default_nettype none
module tccr_cpu (
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  output var  logic [7:0] addr,
  output var  logic       io_space,
  output var  logic       wr_en,
  output var  logic       rd_en,
  output var  logic [7:0] wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {addr, io_space, wr_en, rd_en, wdata} = '0;
  // entered at a falling edge; strobes stay up so back-to-back accesses never glitch
  task automatic acc(input logic w, input logic [7:0] a, input logic io,
                     input logic [7:0] d, output logic [7:0] q);
    addr = a;
    io_space = io;
    wr_en = w;
    rd_en = !w;
    wdata = w ? d : ~wdata;
    @(posedge clk);
    @(negedge clk);
    q = rdata;
  endtask
  task automatic idle();
    wr_en = 1'h0;
    rd_en = 1'h0;
    wdata = ~wdata;
  endtask
  task automatic wr16(input logic [7:0] a, input logic io, input logic [15:0] v);
    logic [7:0] q;
    acc(1'h1, a + 8'h01, io, v[15:8], q);
    acc(1'h1, a, io, v[7:0], q);
  endtask
  task automatic rd16(input logic [7:0] a, input logic io, output logic [15:0] v);
    acc(1'h0, a, io, 8'h00, v[7:0]);
    acc(1'h0, a + 8'h01, io, 8'h00, v[15:8]);
  endtask
endmodule
`default_nettype wire

// File: verification/tccr_monitor.sv
// assertions on the ports of the compare/capture register set
`default_nettype none
module tccr_monitor (
  input wire logic        CLK,
  input wire logic        NRST,
  input wire logic [7:0]  ADDR,
  input wire logic        IO_SPACE,
  input wire logic        WR_EN,
  input wire logic        RD_EN,
  input wire logic [7:0]  WDATA,
  input wire logic [7:0]  RDATA,
  input wire logic [15:0] T1_CAPTURE,
  input wire logic [15:0] T1_MATCH_C,
  input wire logic [15:0] T1_TOP_VALUE,
  input wire logic        T1_CAPTURE_EVENT,
  input wire logic        T1_MATCH_BLOCK,
  input wire logic        T3_MATCH_BLOCK,
  input wire logic        T1_COUNT_WRITE,
  input wire logic        T3_COUNT_WRITE,
  input wire logic        T3_TIMER_TICK
);
  default clocking dc @(posedge CLK); endclocking
  default disable iff (!NRST);
  sequence lo_rd;
    RD_EN && ADDR == 8'h78 && !IO_SPACE;
  endsequence
  sequence hi_rd;
    RD_EN && ADDR == 8'h79 && !IO_SPACE;
  endsequence
  hi_staged_a:
    assert property (WR_EN && ADDR == 8'h79 && !IO_SPACE |=> $stable(T1_MATCH_C))
    else $error("high byte write moved compare C");
  lo_commit_a:
    assert property (WR_EN && ADDR == 8'h78 && !IO_SPACE |=> T1_MATCH_C[7:0] == $past(WDATA))
    else $error("low byte write not committed");
  read_pair_a:
    assert property (lo_rd ##1 hi_rd |=> RDATA == $past(T1_MATCH_C[15:8], 2))
    else $error("high read did not return latched byte");
  event_pulse_a:
    assert property (T1_CAPTURE_EVENT |=> !T1_CAPTURE_EVENT)
    else $error("capture event longer than one cycle");
  capture_cause_a:
    assert property ($changed(T1_CAPTURE) && !$past(WR_EN) |-> T1_CAPTURE_EVENT)
    else $error("capture moved without event");
  top_value_a:
    assert property (T1_TOP_VALUE == T1_CAPTURE)
    else $error("top value differs from capture");
  block_set_a:
    assert property (T1_COUNT_WRITE |=> T1_MATCH_BLOCK)
    else $error("counter write did not block matches");
  block_clear_a:
    assert property (T3_MATCH_BLOCK && T3_TIMER_TICK && !T3_COUNT_WRITE |=> !T3_MATCH_BLOCK)
    else $error("match block outlived the tick");
endmodule
bind tccr_regs tccr_monitor u_mon (.*);
`default_nettype wire

// File: verification/test_timer_compare_capture_regs.sv
// self-checking bench for the compare/capture register set
`default_nettype none
module test_timer_compare_capture_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, nrst = 0, pin = 0, cmp = 0, sel = 0, cw1 = 0, cw3 = 0, tk1 = 0, tk3 = 0;
  logic rise = 1, topsel = 1, tfc;
  logic [15:0] cnt = 16'h0000, v, cap, m1c, m3a, m3b, m3c, top;
  logic [7:0]  addr, wdata, rdata, q;
  logic        io, wr, rd, evt, blk1, blk3;
  int          err_total = 0, tests_run = 0;
  logic [7:0]  lo [5] = '{8'h46, 8'h78, 8'h86, 8'h84, 8'h82};
  initial forever #20 clk = ~clk;
  tccr_cpu cpu (.clk(clk), .rdata(rdata), .addr(addr), .io_space(io), .wr_en(wr),
    .rd_en(rd), .wdata(wdata));
  tccr_regs i_dut (.CLK(clk), .NRST(nrst), .ADDR(addr), .IO_SPACE(io), .WR_EN(wr),
    .RD_EN(rd), .WDATA(wdata), .RDATA(rdata), .T1_TIMER_COUNT_VALUE(cnt),
    .T3_TIMER_COUNT_VALUE(16'h0000), .T1_CAPTURE_TRIGGER_PIN(pin), .T1_COMPARATOR_OUT(cmp),
    .T1_SEL_COMPARATOR(sel), .T1_CAPTURE_RISING(rise), .T1_TOP_IS_CAPTURE(topsel),
    .T1_COUNT_WRITE(cw1), .T3_COUNT_WRITE(cw3), .T1_TIMER_TICK(tk1), .T3_TIMER_TICK(tk3),
    .T1_CAPTURE(cap), .T1_MATCH_C(m1c), .T3_MATCH_A(m3a), .T3_MATCH_B(m3b),
    .T3_MATCH_C(m3c), .T1_TOP_VALUE(top), .T1_CAPTURE_EVENT(evt),
    .T1_MATCH_BLOCK(blk1), .T3_MATCH_BLOCK(blk3), .T1_TOP_FROM_CAPTURE(tfc));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [15:0] ev(input int i);
    return {4'hA, i[3:0], 4'h5, ~i[3:0]};
  endfunction
  function automatic logic [15:0] out16(input int i);
    logic [79:0] all;
    all = {cap, m1c, m3a, m3b, m3c};
    return all[79-16*i -: 16];
  endfunction
  // bounded wait: the event is due three edges after the trigger moves
  task automatic wait_evt();
    for (int n = 0; n < 8 && evt !== 1'h1; n++) @(negedge clk);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #100us;
    err_total++;
    stop_test();
  end
  initial begin
    repeat (5) @(negedge clk);
    nrst = 1;
    for (int i = 0; i < 5; i++) begin
      cpu.rd16(lo[i], 1'h0, v);
      chk("reset value", 16'h0000, v);
    end
    $display("test reset values done");
    // ****************
    // all five words share one latch, written back to back
    // ****************
    for (int i = 0; i < 5; i++) cpu.wr16(i == 0 ? 8'h26 : lo[i], i == 0, ev(i));
    for (int i = 0; i < 5; i++) chk("register port", ev(i), out16(i));
    for (int i = 0; i < 5; i++) begin
      cpu.rd16(lo[i], 1'h0, v);
      chk("readback", ev(i), v);
    end
    cpu.acc(1'h1, 8'h79, 1'h0, 8'hEE, q);
    cpu.idle();
    @(negedge clk);
    chk("staged high", ev(1), m1c);
    cpu.acc(1'h1, 8'h78, 1'h0, 8'h11, q);
    cpu.acc(1'h1, 8'h78, 1'h1, 8'h77, q);
    cpu.acc(1'h0, 8'h50, 1'h0, 8'h00, q);
    cpu.idle();
    chk("unmapped read", 16'h0000, {8'h00, q});
    chk("commit", 16'hEE11, m1c);
    $display("test byte access done");
    cnt = 16'h3C5A;
    pin = 1;
    wait_evt();
    chk("pin capture", 16'h3C5A, cap);
    chk("top value", 16'h3C5A, top);
    chk("capture event", 16'h0001, {15'h0000, evt});
    chk("top select on", 16'h0001, {15'h0000, tfc});
    sel = 1;
    cnt = 16'h0F0F;
    repeat (4) @(negedge clk);
    cmp = 1;
    wait_evt();
    chk("comparator capture", 16'h0F0F, cap);
    sel = 0;
    rise = 0;
    topsel = 0;
    cnt = 16'h1234;
    repeat (2) @(negedge clk);
    chk("top select off", 16'h0000, {15'h0000, tfc});
    pin = 0;
    wait_evt();
    chk("falling capture", 16'h1234, cap);
    $display("test capture done");
    cw1 = 1;
    cw3 = 1;
    @(negedge clk);
    cw1 = 0;
    cw3 = 0;
    repeat (3) @(negedge clk);
    chk("block held", 16'h0003, {14'h0000, blk1, blk3});
    tk1 = 1;
    tk3 = 1;
    @(negedge clk);
    tk1 = 0;
    tk3 = 0;
    @(negedge clk);
    chk("block cleared", 16'h0000, {14'h0000, blk1, blk3});
    $display("test match block done");
    stop_test();
  end
endmodule
`default_nettype wire
